// [hdl/ltab_defs.svh]
// register offsets, persistence sample counts, reset values and widths for the
// limit and alert bank; included by the package and the modules
`ifndef LTAB_DEFS_SVH
`define LTAB_DEFS_SVH

`define LTAB_NCH 4
`define LTAB_ADDR_W 8
`define LTAB_DATA_W 24
`define LTAB_LIM_W 16
`define LTAB_OP_W 24
`define LTAB_PWR_W 32
`define LTAB_CNT_W 5

`define LTAB_OC_BASE 8'h30
`define LTAB_UC_BASE 8'h34
`define LTAB_OP_BASE 8'h38
`define LTAB_OV_BASE 8'h3C
`define LTAB_UV_BASE 8'h40
`define LTAB_PERSIST_ADDR 8'h44

`define LTAB_LIM_RST 16'h0000
`define LTAB_OP_RST 24'h000000
`define LTAB_PERSIST_RST 8'h00

`define LTAB_NEED_00 5'h01
`define LTAB_NEED_01 5'h04
`define LTAB_NEED_10 5'h08
`define LTAB_NEED_11 5'h10

`endif

// [hdl/ltab_persist.sv]
// consecutive-sample filter for one channel's overcurrent flag
// assumes conv_i is a one-cycle pulse per completed conversion
`timescale 1ns/1ps
`include "ltab_defs.svh"

module ltab_persist (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic conv_i,
    input wire logic viol_i,
    input wire logic [1:0] code_i,
    output logic flag_o,
    output logic [`LTAB_CNT_W-1:0] count_o
);
    import ltab_pkg::*;

    logic [`LTAB_CNT_W-1:0] cnt_r, cnt_nxt;
    logic flag_r, flag_nxt;

    // samples needed before the flag rises
    function automatic logic [`LTAB_CNT_W-1:0] need_f(input logic [1:0] c);
        case (c)
            2'h0: need_f = `LTAB_NEED_00;
            2'h1: need_f = `LTAB_NEED_01;
            2'h2: need_f = `LTAB_NEED_10;
            default: need_f = `LTAB_NEED_11;
        endcase
    endfunction

    ////////////////////////////////////////////////////////////////////
    // count saturates at sixteen so a long fault never wraps to zero
    always_comb begin
        cnt_nxt = cnt_r;
        flag_nxt = flag_r;
        if (conv_i) begin
            if (viol_i) begin
                if (cnt_r != `LTAB_NEED_11) begin
                    cnt_nxt = cnt_r + 5'h01;
                end
                if (cnt_nxt >= need_f(code_i)) begin // (R8)
                    flag_nxt = 1'b1;
                end
            end else begin
                cnt_nxt = 5'h00; // (R10)
                flag_nxt = 1'b0; // (R11)
            end
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cnt_r <= 5'h00;
            flag_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            flag_r <= flag_nxt;
        end
    end

    assign flag_o = flag_r;
    assign count_o = cnt_r;

    ////////////////////////////////////////////////////////////////////
    count_hold_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        !conv_i |=> $stable(cnt_r) && $stable(flag_r)) // (R10)
        else $error("persistence state moved without a conversion");

    single_sample_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        conv_i && viol_i && code_i == 2'h0 |=> flag_r) // (R9)
        else $error("code 00 did not flag on first violation");

    flag_needs_count_a: assert property (@(posedge clk_i)
        disable iff (sys_rst_i)
        $rose(flag_r) |-> cnt_r >= need_f($past(code_i))) // (R8)
        else $error("flag rose before enough consecutive samples");

    release_one_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        conv_i && !viol_i |=> !flag_r && cnt_r == 5'h00) // (R11)
        else $error("clean conversion did not release the flag");

endmodule

// [hdl/ltab_pkg.sv]
// types shared by the limit bank and its persistence filter
// assumes ltab_defs.svh is on the include path
`include "ltab_defs.svh"

package ltab_pkg;

    typedef logic signed [`LTAB_LIM_W-1:0] ltab_lim_t;
    typedef logic signed [`LTAB_OP_W-1:0] ltab_op_t;

    // one channel's conversion result
    typedef struct packed {
        logic signed [`LTAB_LIM_W-1:0] current;
        logic signed [`LTAB_LIM_W-1:0] voltage;
        logic signed [`LTAB_PWR_W-1:0] power;
    } ltab_meas_s;

    // per-channel qualified limit flags, bit 0 is channel 1
    typedef struct packed {
        logic [`LTAB_NCH-1:0] oc;
        logic [`LTAB_NCH-1:0] uc;
        logic [`LTAB_NCH-1:0] op;
        logic [`LTAB_NCH-1:0] ov;
        logic [`LTAB_NCH-1:0] uv;
    } ltab_flags_s;

endpackage

// [hdl/ltab_top.sv]
// threshold registers and limit comparators for four channels
// assumes a register port already decoded from the serial bus and a
// one-cycle conversion-complete pulse with stable results beside it
//
// Contract
// (R1) Four 16-bit signed overcurrent thresholds live at 30h..33h.
// (R2) Four 16-bit signed undercurrent thresholds live at 34h..37h.
// (R3) The 24-bit signed overpower threshold meets the top power bits.
// (R4) Overpower alone is by magnitude, past the limit either way.
// (R5) Four overpower thresholds live at 38h..3Bh, channel 1 first.
// (R6) Four 16-bit signed overvoltage thresholds live at 3Ch..3Fh.
// (R7) Four 16-bit signed undervoltage thresholds live at 40h..43h.
// (R8) Two bits per channel pick 1, 4, 8 or 16 overcurrent samples.
// (R9) Persistence codes come up as 00, one sample raises the alert.
// (R10) The sample count holds until a clean conversion clears it.
// (R11) One clean conversion releases the overcurrent alert state.
// (R12) The host should mask alerts before rewriting any setting.
// (R13) Over flags on greater-than, under flags on less-than, signed.
// (R14) Every threshold and persistence register is read/write, zero.
`timescale 1ns/1ps
`include "ltab_defs.svh"

module ltab_top (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic [`LTAB_ADDR_W-1:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic [`LTAB_DATA_W-1:0] reg_wdata_i,
    input wire logic reg_rd_i,
    output logic [`LTAB_DATA_W-1:0] reg_rdata_o,
    input wire logic conv_done_i,
    input wire ltab_pkg::ltab_meas_s [`LTAB_NCH-1:0] meas_i,
    output ltab_pkg::ltab_flags_s flags_o,
    output logic alert_o
);
    import ltab_pkg::*;

    localparam int NCH = `LTAB_NCH;

    ltab_lim_t oc_r [NCH];
    ltab_lim_t uc_r [NCH];
    ltab_op_t op_r [NCH];
    ltab_lim_t ov_r [NCH];
    ltab_lim_t uv_r [NCH];
    ltab_lim_t oc_nxt [NCH];
    ltab_lim_t uc_nxt [NCH];
    ltab_op_t op_nxt [NCH];
    ltab_lim_t ov_nxt [NCH];
    ltab_lim_t uv_nxt [NCH];
    logic [7:0] persist_r, persist_nxt;
    logic [`LTAB_DATA_W-1:0] rdata_r, rdata_nxt;
    ltab_flags_s flags_r, flags_nxt, flags_out;
    logic [NCH-1:0] oc_viol, oc_flag;

    // true when addr is the word for channel ch in the block starting at base
    function automatic logic hit_f(input logic [7:0] a, input logic [7:0] b,
                                   input int ch);
        hit_f = (a == b + ch[7:0]);
    endfunction

    // magnitude test on the top power bits against the limit
    function automatic logic op_f(input ltab_meas_s m, input ltab_op_t t);
        logic signed [`LTAB_OP_W:0] top;
        logic signed [`LTAB_OP_W:0] mag;
        top = {m.power[`LTAB_PWR_W-1], m.power[`LTAB_PWR_W-1 -: `LTAB_OP_W]};
        mag = t[`LTAB_OP_W-1] ? -{t[`LTAB_OP_W-1], t} : {1'b0, t};
        op_f = (top > mag) || (top < -mag);
    endfunction

    ////////////////////////////////////////////////////////////////////
    // register writes; the host is expected to mask alerts first since
    // a new limit takes effect on the very next conversion
    always_comb begin
        persist_nxt = persist_r;
        for (int i = 0; i < NCH; i++) begin
            oc_nxt[i] = oc_r[i];
            uc_nxt[i] = uc_r[i];
            op_nxt[i] = op_r[i];
            ov_nxt[i] = ov_r[i];
            uv_nxt[i] = uv_r[i];
            if (reg_wr_i) begin
                if (hit_f(reg_addr_i, `LTAB_OC_BASE, i)) begin
                    oc_nxt[i] = reg_wdata_i[15:0]; // (R1)
                end
                if (hit_f(reg_addr_i, `LTAB_UC_BASE, i)) begin
                    uc_nxt[i] = reg_wdata_i[15:0]; // (R2)
                end
                if (hit_f(reg_addr_i, `LTAB_OP_BASE, i)) begin
                    op_nxt[i] = reg_wdata_i; // (R5)
                end
                if (hit_f(reg_addr_i, `LTAB_OV_BASE, i)) begin
                    ov_nxt[i] = reg_wdata_i[15:0]; // (R6)
                end
                if (hit_f(reg_addr_i, `LTAB_UV_BASE, i)) begin
                    uv_nxt[i] = reg_wdata_i[15:0]; // (R7)
                end
            end
        end
        if (reg_wr_i && reg_addr_i == `LTAB_PERSIST_ADDR) begin
            persist_nxt = reg_wdata_i[7:0]; // (R8)
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            persist_r <= `LTAB_PERSIST_RST; // (R9)
            for (int i = 0; i < NCH; i++) begin
                oc_r[i] <= `LTAB_LIM_RST; // (R14)
                uc_r[i] <= `LTAB_LIM_RST;
                op_r[i] <= `LTAB_OP_RST;
                ov_r[i] <= `LTAB_LIM_RST;
                uv_r[i] <= `LTAB_LIM_RST;
            end
        end else begin
            persist_r <= persist_nxt;
            for (int i = 0; i < NCH; i++) begin
                oc_r[i] <= oc_nxt[i];
                uc_r[i] <= uc_nxt[i];
                op_r[i] <= op_nxt[i];
                ov_r[i] <= ov_nxt[i];
                uv_r[i] <= uv_nxt[i];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // read mux; unmapped addresses return zero, narrow regs zero-fill
    always_comb begin
        rdata_nxt = rdata_r;
        if (reg_rd_i) begin
            rdata_nxt = '0;
            for (int i = 0; i < NCH; i++) begin
                if (hit_f(reg_addr_i, `LTAB_OC_BASE, i)) begin
                    rdata_nxt = {8'h00, oc_r[i]}; // (R14)
                end
                if (hit_f(reg_addr_i, `LTAB_UC_BASE, i)) begin
                    rdata_nxt = {8'h00, uc_r[i]};
                end
                if (hit_f(reg_addr_i, `LTAB_OP_BASE, i)) begin
                    rdata_nxt = op_r[i];
                end
                if (hit_f(reg_addr_i, `LTAB_OV_BASE, i)) begin
                    rdata_nxt = {8'h00, ov_r[i]};
                end
                if (hit_f(reg_addr_i, `LTAB_UV_BASE, i)) begin
                    rdata_nxt = {8'h00, uv_r[i]};
                end
            end
            if (reg_addr_i == `LTAB_PERSIST_ADDR) begin
                rdata_nxt = {16'h0000, persist_r};
            end
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            rdata_r <= '0;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // overcurrent goes through the persistence filter; channel 1 owns
    // the top field of the persistence byte
    for (genvar g = 0; g < NCH; g++) begin : g_oc
        assign oc_viol[g] = meas_i[g].current > oc_r[g]; // (R13)
        ltab_persist u_persist (
            .clk_i(clk_i),
            .sys_rst_i(sys_rst_i),
            .conv_i(conv_done_i),
            .viol_i(oc_viol[g]),
            .code_i(persist_r[7-2*g -: 2]), // (R8)
            .flag_o(oc_flag[g]),
            .count_o()
        );
    end

    ////////////////////////////////////////////////////////////////////
    // the other limits qualify on a single conversion
    always_comb begin
        flags_nxt = flags_r;
        if (conv_done_i) begin
            for (int i = 0; i < NCH; i++) begin
                flags_nxt.uc[i] = meas_i[i].current < uc_r[i]; // (R13)
                flags_nxt.ov[i] = meas_i[i].voltage > ov_r[i]; // (R13)
                flags_nxt.uv[i] = meas_i[i].voltage < uv_r[i]; // (R13)
                flags_nxt.op[i] = op_f(meas_i[i], op_r[i]); // (R3) (R4)
            end
        end
    end

    always_ff @(posedge clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            flags_r <= '0;
        end else begin
            flags_r <= flags_nxt;
        end
    end

    // the overcurrent field comes straight from the filter flops; a
    // second register here would leave it one conversion behind
    always_comb begin
        flags_out = flags_r;
        flags_out.oc = oc_flag; // (R11)
    end

    assign flags_o = flags_out;
    assign alert_o = |flags_out; // level, any flag on any channel
    assign reg_rdata_o = rdata_r;

    ////////////////////////////////////////////////////////////////////
    oc_write_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        reg_wr_i && reg_addr_i == 8'h33 |=>
        oc_r[3] == $past(reg_wdata_i[15:0])) // (R1)
        else $error("channel 4 overcurrent limit not written");

    op_read_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        reg_rd_i && !reg_wr_i && reg_addr_i == 8'h38 |=>
        reg_rdata_o == op_r[0]) // (R5)
        else $error("overpower limit readback wrong");

    uc_flag_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        conv_done_i && meas_i[1].current < uc_r[1] |=> flags_o.uc[1]) // (R2)
        else $error("undercurrent not flagged");

    ov_flag_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        conv_done_i && meas_i[2].voltage <= ov_r[2] |=> !flags_o.ov[2]) // (R6)
        else $error("overvoltage flagged at or under limit");

    uv_flag_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        conv_done_i && meas_i[3].voltage < uv_r[3] |=> flags_o.uv[3]) // (R7)
        else $error("undervoltage not flagged");

    op_negative_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        conv_done_i && !op_r[0][23] &&
        $signed(meas_i[0].power[31 -: 24]) < -$signed({1'b0, op_r[0]})
        |=> flags_o.op[0]) // (R4)
        else $error("negative overpower not flagged");

    alert_tie_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        flags_o.oc[0] |-> alert_o) // (R11)
        else $error("overcurrent flag not on alert");

    persist_rw_a: assert property (@(posedge clk_i) disable iff (sys_rst_i)
        reg_wr_i && reg_addr_i == 8'h44 ##1 reg_rd_i && !reg_wr_i &&
        reg_addr_i == 8'h44 |=> reg_rdata_o[7:0] == $past(persist_r)) // (R14)
        else $error("persistence readback wrong");

    uc_write_a: assert property ( // (R2)
        @(posedge clk_i) disable iff (sys_rst_i)
        reg_wr_i && reg_addr_i == 8'h34 |=>
        uc_r[0] == $past(reg_wdata_i[15:0]))
        else $error("channel 1 undercurrent limit not written");

    op_write_a: assert property ( // (R5)
        @(posedge clk_i) disable iff (sys_rst_i)
        reg_wr_i && reg_addr_i == 8'h3B |=> op_r[3] == $past(reg_wdata_i))
        else $error("channel 4 overpower limit not written");

    ov_write_a: assert property ( // (R6)
        @(posedge clk_i) disable iff (sys_rst_i)
        reg_wr_i && reg_addr_i == 8'h3C |=>
        ov_r[0] == $past(reg_wdata_i[15:0]))
        else $error("channel 1 overvoltage limit not written");

    uv_write_a: assert property ( // (R7)
        @(posedge clk_i) disable iff (sys_rst_i)
        reg_wr_i && reg_addr_i == 8'h43 |=>
        uv_r[3] == $past(reg_wdata_i[15:0]))
        else $error("channel 4 undervoltage limit not written");

    persist_write_a: assert property ( // (R8)
        @(posedge clk_i) disable iff (sys_rst_i)
        reg_wr_i && reg_addr_i == 8'h44 |=>
        persist_r == $past(reg_wdata_i[7:0]))
        else $error("persistence codes not written");

    unmapped_read_a: assert property ( // (R14)
        @(posedge clk_i) disable iff (sys_rst_i)
        reg_rd_i && reg_addr_i == 8'h45 |=> reg_rdata_o == 24'h000000)
        else $error("unmapped address did not read zero");

    oc_single_a: assert property ( // (R9)
        @(posedge clk_i) disable iff (sys_rst_i)
        conv_done_i && persist_r[7:6] == 2'h0 &&
        meas_i[0].current > oc_r[0] |=> flags_o.oc[0])
        else $error("code 00 overcurrent not on the next cycle");

    oc_release_a: assert property ( // (R11)
        @(posedge clk_i) disable iff (sys_rst_i)
        conv_done_i && meas_i[0].current <= oc_r[0] |=> !flags_o.oc[0])
        else $error("clean conversion left the overcurrent flag up");

    op_positive_a: assert property ( // (R4)
        @(posedge clk_i) disable iff (sys_rst_i)
        conv_done_i && !op_r[1][23] &&
        $signed(meas_i[1].power[31 -: 24]) > $signed({1'b0, op_r[1]})
        |=> flags_o.op[1])
        else $error("positive overpower not flagged");

endmodule

// [verification/limit_threshold_alert_bank_tb.sv]
// self-checking bench for the limit and alert bank
// assumes the package and the host model are compiled first
`timescale 1ns/1ps
`include "ltab_defs.svh"
`define CHK(g, e) check(32'(g), 32'(e))

module limit_threshold_alert_bank_tb;
    import ltab_pkg::*;
    logic clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic conv_done_i = 1'b0;
    logic [7:0] addr;
    logic wr;
    logic rd;
    logic [23:0] wdata;
    logic [23:0] rdata;
    ltab_meas_s [3:0] meas = '0;
    ltab_flags_s flags;
    logic alert;
    logic [23:0] sh [0:21]; // shadow map, entry 21 is unmapped 45h
    int cnt [0:3];
    logic [3:0] ocf = 4'h0; // filtered overcurrent flag, latched per fault
    int miscompares = 0;
    int compares = 0;
    int mode = -1; // -1 random current, 0 at limit, 1 above limit

    always #2.5 clk_i = ~clk_i;

    ltab_host_model host (
        .clk_i(clk_i),
        .addr_o(addr),
        .wr_o(wr),
        .rd_o(rd),
        .wdata_o(wdata),
        .rdata_i(rdata)
    );

    ltab_top dut (
        .clk_i(clk_i),
        .sys_rst_i(sys_rst_i),
        .reg_addr_i(addr),
        .reg_wr_i(wr),
        .reg_wdata_i(wdata),
        .reg_rd_i(rd),
        .reg_rdata_o(rdata),
        .conv_done_i(conv_done_i),
        .meas_i(meas),
        .flags_o(flags),
        .alert_o(alert)
    );

    ////////////////////////////////////////////////////////////////////
    task automatic check(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e) begin
            miscompares++;
            $display("mismatch at %0t: got %h expected %h", $time, g, e);
        end
    endtask

    task automatic stop_test();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    // writable bits per map entry; unmapped keeps nothing
    function automatic logic [23:0] wmask(int i);
        if (i == 21) return 24'h000000;
        if (i == 20) return 24'h0000FF;
        return (i >= 8 && i < 12) ? 24'hFFFFFF : 24'h00FFFF;
    endfunction

    // half the time a value within one of the limit, to hit the boundary
    function automatic logic [15:0] pick(logic [15:0] t);
        return ($urandom % 2) ? 16'($urandom)
                              : 16'(t + 16'($urandom % 3) - 16'h0001);
    endfunction

    task automatic put(int i, logic [23:0] d);
        host.wr(8'h30 + 8'(i), d);
        sh[i] = d & wmask(i);
    endtask

    ////////////////////////////////////////////////////////////////////
    // one conversion, expectations from the shadow map
    task automatic conv(int gap);
        logic [19:0] e;
        int t;
        int top;
        int code;
        e = '0;
        @(negedge clk_i);
        for (int k = 0; k < 4; k++) begin
            meas[k].current = (mode < 0) ? pick(sh[k][15:0])
                                         : sh[k][15:0] + 16'(mode);
            meas[k].voltage = pick(sh[12 + 4 * (k % 2) + k][15:0]);
            t = $signed(sh[8 + k]);
            t = (t < 0) ? -t : t;
            top = (($urandom % 2) ? t : -t) + int'($urandom % 3) - 1;
            meas[k].power = {24'(top), 8'($urandom)};
            if ($urandom % 4 == 0) meas[k].power = $urandom;
            if ($signed(meas[k].current) > $signed(sh[k][15:0]))
                cnt[k] = (cnt[k] < 16) ? cnt[k] + 1 : 16;
            else
                cnt[k] = 0;
            code = sh[20][7 - 2 * k -: 2];
            // once up, the flag stays until a clean conversion
            ocf[k] = cnt[k] > 0 &&
                (ocf[k] || cnt[k] >= ((code == 0) ? 1 : 4 << (code - 1)));
            e[16 + k] = ocf[k];
            e[12 + k] = $signed(meas[k].current) < $signed(sh[4 + k][15:0]);
            top = $signed(meas[k].power[31:8]);
            e[8 + k] = (top > t) || (top < -t);
            e[4 + k] = $signed(meas[k].voltage) > $signed(sh[12 + k][15:0]);
            e[k] = $signed(meas[k].voltage) < $signed(sh[16 + k][15:0]);
        end
        conv_done_i = 1'b1;
        @(negedge clk_i);
        conv_done_i = 1'b0;
        `CHK(flags, e);
        `CHK(alert, |e);
        repeat (gap) @(negedge clk_i);
    endtask

    ////////////////////////////////////////////////////////////////////
    initial begin
        logic [23:0] d;
        void'($urandom(49));
        sh = '{default: '0};
        cnt = '{default: 0};
        repeat (8) @(posedge clk_i);
        @(negedge clk_i);
        sys_rst_i = 1'b0;
        // reset values, random fill, full readback including 45h
        for (int i = 0; i < 22; i++) begin
            host.rd(8'h30 + 8'(i), d);
            `CHK(d, 24'h0);
        end
        for (int i = 0; i < 22; i++) put(i, 24'($urandom));
        for (int i = 0; i < 22; i++) begin
            host.rd(8'h30 + 8'(i), d);
            `CHK(d, sh[i]);
        end
        // random limits and codes rewritten between bursts
        repeat (20) begin
            put($urandom % 21, 24'($urandom));
            repeat (10) conv($urandom % 3);
        end
        // every code across the four channels, two codes per channel, both field orders
        for (int i = 0; i < 4; i++) put(i, 24'h0);
        for (int j = 0; j < 2; j++) begin
            put(20, j ? 24'hE4 : 24'h1B);
            mode = 1;
            repeat (17) conv(2);
            mode = 0;
            conv(0);
            mode = 1;
            conv(0);
        end
        stop_test();
    end

    // watchdog at ten thousand cycles, far beyond the thousand or so the run needs
    initial begin
        #50000;
        miscompares++;
        stop_test();
    end
endmodule

// [verification/ltab_host_model.sv]
// host side of the decoded register port, write and read tasks
// assumes a free-running clk_i; drives on the falling edge
`timescale 1ns/1ps
`include "ltab_defs.svh"

module ltab_host_model (
    input wire logic clk_i,
    output logic [`LTAB_ADDR_W-1:0] addr_o,
    output logic wr_o,
    output logic rd_o,
    output logic [`LTAB_DATA_W-1:0] wdata_o,
    input wire logic [`LTAB_DATA_W-1:0] rdata_i
);
    // idle bus at time zero
    initial begin
        addr_o = 8'h00;
        wr_o = 1'b0;
        rd_o = 1'b0;
        wdata_o = 24'h000000;
    end

    // one-cycle strobe; callers write only between conversions
    task automatic wr(input logic [7:0] a, input logic [23:0] d);
        @(negedge clk_i);
        addr_o = a;
        wdata_o = d;
        wr_o = 1'b1;
        @(negedge clk_i);
        wr_o = 1'b0;
        wdata_o = ~d; // stale data never looks valid
    endtask

    // data is taken one cycle after the strobe edge
    task automatic rd(input logic [7:0] a, output logic [23:0] d);
        @(negedge clk_i);
        addr_o = a;
        rd_o = 1'b1;
        @(negedge clk_i);
        rd_o = 1'b0;
        d = rdata_i;
    endtask
endmodule
